// ### pkg/tmr_pkg.sv
// Constants for the split-capable sixteen-bit timer.
// Assumes one peripheral clock; all control bits arrive as plain ports.
package tmr_pkg;
  localparam int          CNT_W          = 16;
  localparam int          BYTE_W         = 8;
  localparam int          NUM_CH         = 3;
  localparam int          PSC_W          = 10;
  // Waveform mode encodings
  localparam logic [2:0]  WG_NORMAL      = 3'h0;
  localparam logic [2:0]  WG_FRQ         = 3'h1;
  localparam logic [2:0]  WG_SINGLESLOPE = 3'h3;
  localparam logic [2:0]  WG_DSTOP       = 3'h5;
  localparam logic [2:0]  WG_DSBOTH      = 3'h6;
  localparam logic [2:0]  WG_DSBOTTOM    = 3'h7;
  // Command encodings
  localparam logic [1:0]  CMD_NONE       = 2'h0;
  localparam logic [1:0]  CMD_UPDATE     = 2'h1;
  localparam logic [1:0]  CMD_RESTART    = 2'h2;
  localparam logic [1:0]  CMD_RESET      = 2'h3;
  // Event actions
  localparam logic [1:0]  EV_POSEDGE     = 2'h0;
  localparam logic [1:0]  EV_ANYEDGE     = 2'h1;
  localparam logic [1:0]  EV_HIGHLVL     = 2'h2;
  localparam logic [1:0]  EV_UPDOWN      = 2'h3;
  // Reset values and limits
  localparam logic [15:0] PER_RESET      = 16'hFFFF;
  localparam logic [15:0] PER_MIN        = 16'h0003;
  localparam logic [15:0] CMP_RESET      = 16'h0000;
  localparam logic [2:0]  PSC_SEL_RESET  = 3'h0;
  // Interrupt vector offsets, normal then split
  localparam logic [7:0]  VEC_OVF        = 8'h00;
  localparam logic [7:0]  VEC_COMPARE0_VECTOR       = 8'h04;
  localparam logic [7:0]  VEC_CMP1       = 8'h06;
  localparam logic [7:0]  VEC_CMP2       = 8'h08;
  localparam logic [7:0]  VEC_LOW_UNDERFLOW_VECTOR       = 8'h00;
  localparam logic [7:0]  VEC_HIGH_UNDERFLOW_VECTOR       = 8'h02;
  // Flag bit positions: 0 overflow/low underflow, 1 high underflow, 4..6 compares
  localparam int          FLAG_OVF       = 0;
  localparam int          FLAG_HIGH_UNDERFLOW_VECTOR      = 1;
  localparam int          FLAG_COMPARE0_VECTOR      = 4;
  localparam logic [7:0]  FLAG_MASK      = 8'h73;
endpackage : tmr_pkg

// ### rtl/tmr_prescaler.sv
// Prescaler: one-cycle tick at the selected division of the clock.
// Assumes i_run gates counting; cleared state on reset or restart.
`timescale 1ns/100ps
module tmr_prescaler (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_run,
  input  wire logic       i_clear,
  input  wire logic [2:0] i_select,
  output logic            o_tick
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [PSC_W-1:0] count;
  } psc_state_t;

  psc_state_t       st;
  psc_state_t       next_st;
  logic [PSC_W-1:0] mask;

  always_comb begin
    case (i_select) // R24
      3'h0:    mask = 10'h000;
      3'h1:    mask = 10'h001;
      3'h2:    mask = 10'h003;
      3'h3:    mask = 10'h007;
      3'h4:    mask = 10'h00F;
      3'h5:    mask = 10'h03F;
      3'h6:    mask = 10'h0FF;
      default: mask = 10'h3FF;
    endcase
  end

  assign o_tick = i_run && ((st.count & mask) == mask);

  always_comb begin
    next_st = st;
    if (i_clear) begin
      next_st.count = '0;
    end else if (i_run) begin
      next_st.count = st.count + 10'h001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tmr_prescaler

// ### rtl/tmr_compare_out.sv
// One compare channel: match detect and waveform bit.
// Assumes the owner supplies count, compare value and slope events.
`timescale 1ns/100ps
module tmr_compare_out (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_tick,
  input  wire logic        i_clear,
  input  wire logic        i_split,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_count_up,
  input  wire logic        i_at_bottom,
  input  wire logic        i_at_top,
  input  wire logic [15:0] i_count,
  input  wire logic [15:0] i_compare,
  output logic             o_match,
  output logic             o_wave
);
  import tmr_pkg::*;

  typedef struct packed {
    logic wave;
  } cmp_state_t;

  cmp_state_t st;
  cmp_state_t next_st;

  assign o_match = i_split ? (i_count[7:0] == i_compare[7:0]) : (i_count == i_compare);
  assign o_wave  = st.wave;

  always_comb begin
    next_st = st;
    if (i_clear) begin
      next_st.wave = 1'b0; // R06
    end else if (i_tick) begin
      if (i_split) begin
        // Down-counting single slope: set at top reload, clear on match
        if (i_at_bottom) begin
          next_st.wave = 1'b1; // R10
        end else if (o_match) begin
          next_st.wave = 1'b0; // R10
        end
      end else begin
        case (i_mode)
          WG_FRQ: begin
            if (o_match) begin
              next_st.wave = ~st.wave;
            end
          end
          WG_SINGLESLOPE: begin
            if (i_at_top) begin
              next_st.wave = 1'b1;
            end else if (o_match) begin
              next_st.wave = 1'b0;
            end
          end
          WG_DSTOP, WG_DSBOTH, WG_DSBOTTOM: begin
            if (o_match) begin
              next_st.wave = ~i_count_up; // R23
            end else if (i_at_bottom) begin
              next_st.wave = 1'b1; // R23
            end
          end
          default: next_st.wave = st.wave;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tmr_compare_out

// ### rtl/tmr_split_timer.sv
// Sixteen-bit timer with split mode, commands, events and interrupt flags.
// Assumes control bits are held by software logic outside; pins and
// the interrupt controller sit beyond the outputs.
//
// Notes on behaviour
// R01: Period sets dual-slope resolution, 2 to 16 bits.
// R02: Dual-slope cycle spans two periods.
// R03: Enabled channel in waveform mode overrides pin.
// R04: Command strobe acts immediately.
// R05: Update command ignores lock-update.
// R06: Restart clears counter, direction, compare outputs.
// R07: Reset command only while disabled.
// R08: Split gives two 8-bit timers, three channels.
// R09: Split counters count down, independently.
// R10: Split supports single-slope PWM only.
// R11: Split high byte: underflow only, no compare flags.
// R12: Split ignores buffers and event actions.
// R13: Split registers are byte-wise, no temp.
// R14: Mode switch keeps stored values.
// R15: Software disables and resets before mode change.
// R16: Software sets split, period, then enable.
// R17: Event action picks one of four counting behaviours.
// R18: Event counting needs enable, never in split.
// R19: Normal vectors: overflow and three compares.
// R20: Split vectors: two underflows, low compares.
// R21: Request stands while flag and enable set.
// R22: Sleep freezes the timer.
// R23: Dual slope: high at bottom, match toggles by direction.
// R24: Prescaler divides by 1 to 1024.
// R25: Writing one clears a flag.
// R26: Pin inversion lies outside; timer waveform uninverted.
`timescale 1ns/100ps
module tmr_split_timer (
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic               i_enable,
  input  wire logic               i_sleep,
  input  wire logic [2:0]         i_prescaler_select,
  input  wire logic [2:0]         i_waveform_mode_select,
  input  wire logic [2:0]         i_compare_output_enable,
  input  wire logic               i_split_enable,
  input  wire logic               i_lock_update,
  input  wire logic               i_dir_down,
  input  wire logic               i_count_on_event_enable,
  input  wire logic [1:0]         i_event_action_select,
  input  wire logic               i_event,
  input  wire logic               i_cmd_valid,
  input  wire logic [1:0]         i_cmd,
  input  wire logic               i_period_write,
  input  wire logic [15:0]        i_period_data,
  input  wire logic               i_period_buf_write,
  input  wire logic [15:0]        i_period_buf_data,
  input  wire logic [2:0]         i_compare_write,
  input  wire logic [15:0]        i_compare_data,
  input  wire logic [2:0]         i_compare_buf_write,
  input  wire logic [15:0]        i_compare_buf_data,
  input  wire logic               i_byte_write,
  input  wire logic               i_byte_high,
  input  wire logic [7:0]         i_int_enable,
  input  wire logic [7:0]         i_flag_clear,
  input  wire logic [2:0]         i_pin_out,
  output logic [2:0]              o_pin_out,
  output logic [2:0]              o_pin_override,
  output logic [15:0]             o_count,
  output logic [15:0]             o_period,
  output logic [7:0]              o_flags,
  output logic [7:0]              o_irq,
  output logic [7:0]              o_vector,
  output logic                    o_count_up,
  output logic [3:0]              o_buf_valid
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       period_register;
    logic [15:0]       per_buf;
    logic [2:0][15:0]  cmp;
    logic [2:0][15:0]  cmp_buf;
    logic [3:0]        bv;
    logic              down;
    logic [7:0]        flags;
    logic              ev_last;
  } tmr_state_t;

  tmr_state_t  st;
  tmr_state_t  next_st;
  logic        run;
  logic        ptick;
  logic        tick;
  logic        restart;
  logic        hard_reset;
  logic        upd_cmd;
  logic        dual;
  logic        ev_mode;
  logic        ev_rise;
  logic        ev_fall;
  logic        at_top;
  logic        at_bottom;
  logic        lo_unf;
  logic        hi_unf;
  logic        hi_tick;
  logic        natural_upd;
  logic [2:0]  match;
  logic [2:0]  wave;
  logic [15:0] wdata;

  assign run        = i_enable && !i_sleep; // R22
  assign restart    = i_cmd_valid && (i_cmd == CMD_RESTART); // R04
  assign hard_reset = i_cmd_valid && (i_cmd == CMD_RESET) && !i_enable; // R07
  assign upd_cmd    = i_cmd_valid && (i_cmd == CMD_UPDATE); // R04
  assign dual       = (i_waveform_mode_select == WG_DSTOP)
                   || (i_waveform_mode_select == WG_DSBOTH)
                   || (i_waveform_mode_select == WG_DSBOTTOM);
  assign ev_mode    = i_count_on_event_enable && !i_split_enable; // R18
  assign ev_rise    = i_event && !st.ev_last;
  assign ev_fall    = !i_event && st.ev_last;

  tmr_prescaler u_psc (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_run     (run),
    .i_clear   (restart || hard_reset),
    .i_select  (i_prescaler_select),
    .o_tick    (ptick)
  );

  // Count tick selection per event action
  always_comb begin
    tick = ptick;
    if (ev_mode) begin // R17
      case (i_event_action_select)
        EV_POSEDGE: tick = run && ev_rise;
        EV_ANYEDGE: tick = run && (ev_rise || ev_fall);
        EV_HIGHLVL: tick = ptick && i_event;
        default:    tick = ptick;
      endcase
    end
  end

  assign at_top    = (st.cnt == st.period_register);
  assign at_bottom = i_split_enable ? (st.cnt[7:0] == 8'h00) : (st.cnt == 16'h0000);
  assign lo_unf    = i_split_enable && tick && (st.cnt[7:0] == 8'h00); // R20
  assign hi_tick   = i_split_enable && tick;
  assign hi_unf    = hi_tick && (st.cnt[15:8] == 8'h00); // R20
  assign o_count_up = !st.down;

  // Natural update at top (single slope up) or bottom
  always_comb begin
    if (dual) begin
      natural_upd = tick && at_bottom && st.down;
    end else if (st.down) begin
      natural_upd = tick && at_bottom;
    end else begin
      natural_upd = tick && at_top;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tmr_compare_out u_cmp (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_tick      (tick),
        .i_clear     (restart || hard_reset),
        .i_split     (i_split_enable),
        .i_mode      (i_waveform_mode_select),
        .i_count_up  (!st.down),
        .i_at_bottom (at_bottom),
        .i_at_top    (at_top),
        .i_count     (st.cnt),
        .i_compare   (st.cmp[g]),
        .o_match     (match[g]),
        .o_wave      (wave[g])
      );
    end
  endgenerate

  // Byte-wise writes in split mode land in one half only
  always_comb begin
    wdata = i_compare_data;
    if (i_split_enable && i_byte_write) begin // R13
      wdata = i_byte_high ? {i_compare_data[7:0], 8'h00} : {8'h00, i_compare_data[7:0]};
    end
  end

  always_comb begin
    next_st         = st;
    next_st.ev_last = i_event;
    // Counter
    if (tick) begin
      if (i_split_enable) begin // R08
        // Both halves count down and reload from their own period byte
        next_st.cnt[7:0]  = (st.cnt[7:0] == 8'h00) ? st.period_register[7:0]
                                                   : st.cnt[7:0] - 8'h01; // R09
        next_st.cnt[15:8] = (st.cnt[15:8] == 8'h00) ? st.period_register[15:8]
                                                    : st.cnt[15:8] - 8'h01; // R09
      end else if (dual) begin
        // Up to period then down to zero: two periods per cycle
        if (!st.down) begin
          if (st.cnt >= st.period_register) begin
            next_st.down = 1'b1; // R02
            next_st.cnt  = st.cnt - 16'h0001; // R01
          end else begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end else if (st.cnt == 16'h0000) begin
          next_st.down = 1'b0; // R02
          next_st.cnt  = 16'h0001;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end else if (ev_mode && i_event_action_select == EV_UPDOWN) begin
        if (i_event) begin // R17
          next_st.cnt = (st.cnt == 16'h0000) ? st.period_register : st.cnt - 16'h0001;
        end else begin
          next_st.cnt = (st.cnt >= st.period_register) ? 16'h0000 : st.cnt + 16'h0001;
        end
      end else if (st.down) begin
        next_st.cnt = (st.cnt == 16'h0000) ? st.period_register : st.cnt - 16'h0001;
      end else begin
        next_st.cnt = (st.cnt >= st.period_register) ? 16'h0000 : st.cnt + 16'h0001;
      end
    end
    if (!dual && !(ev_mode && i_event_action_select == EV_UPDOWN)) begin
      next_st.down = i_split_enable ? 1'b1 : i_dir_down; // R09
    end
    // Buffer writes and update transfer, ignored in split mode
    if (!i_split_enable) begin // R12
      if (i_period_buf_write) begin
        next_st.per_buf = i_period_buf_data;
        next_st.bv[0]   = 1'b1;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (i_compare_buf_write[i]) begin
          next_st.cmp_buf[i] = i_compare_buf_data;
          next_st.bv[i+1]    = 1'b1;
        end
      end
      if (upd_cmd || (natural_upd && !i_lock_update)) begin // R05
        if (st.bv[0]) begin
          next_st.period_register = st.per_buf;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (st.bv[i+1]) begin
            next_st.cmp[i] = st.cmp_buf[i];
          end
        end
        next_st.bv = 4'h0;
      end
    end
    // Direct writes keep the other byte in split byte access
    if (i_period_write) begin
      if (i_split_enable && i_byte_write) begin // R13
        if (i_byte_high) begin
          next_st.period_register[15:8] = i_period_data[7:0];
        end else begin
          next_st.period_register[7:0] = i_period_data[7:0];
        end
      end else begin
        next_st.period_register = i_period_data;
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (i_compare_write[i]) begin
        if (i_split_enable && i_byte_write) begin
          next_st.cmp[i] = i_byte_high ? {wdata[15:8], st.cmp[i][7:0]}
                                       : {st.cmp[i][15:8], wdata[7:0]};
        end else begin
          next_st.cmp[i] = wdata;
        end
      end
    end
    // Flags: clear by writing one, a new event wins
    next_st.flags = st.flags & ~i_flag_clear; // R25
    if (i_split_enable) begin
      if (lo_unf) begin
        next_st.flags[FLAG_OVF] = 1'b1; // R20
      end
      if (hi_unf) begin
        next_st.flags[FLAG_HIGH_UNDERFLOW_VECTOR] = 1'b1; // R11
      end
    end else if (tick && !st.down && at_top && !dual) begin
      next_st.flags[FLAG_OVF] = 1'b1; // R19
    end else if (tick && dual && at_bottom && st.down) begin
      next_st.flags[FLAG_OVF] = 1'b1; // R19
    end else if (tick && st.down && at_bottom) begin
      next_st.flags[FLAG_OVF] = 1'b1; // R19
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // In split mode only the low-byte match is seen
      if (tick && match[i]) begin
        next_st.flags[FLAG_COMPARE0_VECTOR+i] = 1'b1; // R11
      end
    end
    // Restart: counter and direction to zero
    if (restart) begin
      next_st.cnt  = 16'h0000; // R06
      next_st.down = 1'b0; // R06
    end
    // Hard reset returns everything to initial values; split bit is kept outside
    if (hard_reset) begin
      next_st.cnt     = 16'h0000; // R07
      next_st.period_register     = PER_RESET;
      next_st.per_buf = PER_RESET;
      next_st.cmp     = '0;
      next_st.cmp_buf = '0;
      next_st.bv      = 4'h0;
      next_st.down    = 1'b0;
      next_st.flags   = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st     <= '0;
      st.period_register <= PER_RESET;
      st.per_buf <= PER_RESET;
    end else begin
      st <= next_st; // R14
    end
  end

  // Pin override; inversion is applied by the port, not here
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      o_pin_override[i] = i_compare_output_enable[i]
                       && (i_waveform_mode_select != WG_NORMAL); // R03
      o_pin_out[i]      = o_pin_override[i] ? wave[i] : i_pin_out[i]; // R26
    end
  end

  // Highest-priority pending vector, offset per mode
  always_comb begin
    o_vector = VEC_OVF;
    if (o_irq[FLAG_OVF]) begin
      o_vector = i_split_enable ? VEC_LOW_UNDERFLOW_VECTOR : VEC_OVF;
    end else if (o_irq[FLAG_HIGH_UNDERFLOW_VECTOR]) begin
      o_vector = VEC_HIGH_UNDERFLOW_VECTOR;
    end else if (o_irq[FLAG_COMPARE0_VECTOR]) begin
      o_vector = VEC_COMPARE0_VECTOR;
    end else if (o_irq[FLAG_COMPARE0_VECTOR+1]) begin
      o_vector = VEC_CMP1;
    end else if (o_irq[FLAG_COMPARE0_VECTOR+2]) begin
      o_vector = VEC_CMP2;
    end
  end

  assign o_flags     = st.flags;
  assign o_irq       = st.flags & i_int_enable & FLAG_MASK; // R21
  assign o_count     = st.cnt;
  assign o_period    = st.period_register;
  assign o_buf_valid = st.bv;
endmodule : tmr_split_timer

// ### sim/tmr_split_timer_monitor.sv
// Checker for the split-capable timer: port relations over time.
// Assumes a bind onto tmr_split_timer; sees its ports only.
`timescale 1ns/100ps
module tmr_split_timer_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_enable,
  input wire logic        i_sleep,
  input wire logic        i_split_enable,
  input wire logic        i_cmd_valid,
  input wire logic [1:0]  i_cmd,
  input wire logic        i_period_buf_write,
  input wire logic [7:0]  i_int_enable,
  input wire logic [2:0]  i_pin_out,
  input wire logic [2:0]  o_pin_out,
  input wire logic [2:0]  o_pin_override,
  input wire logic [15:0] o_count,
  input wire logic [15:0] o_period,
  input wire logic [7:0]  o_flags,
  input wire logic [7:0]  o_irq,
  input wire logic [7:0]  o_vector,
  input wire logic [3:0]  o_buf_valid
);
  import tmr_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  AST_IRQ_MASK: assert property (o_irq == (o_flags & i_int_enable))
    else $error("irq differs from flags and enables");
  AST_RESTART: assert property (i_cmd_valid && i_cmd == CMD_RESTART |=> o_count == 16'h0000)
    else $error("restart left count");
  AST_SLEEP: assert property (i_sleep && !i_cmd_valid |=> $stable(o_count))
    else $error("count moved in sleep");
  AST_PIN_PASS: assert property (((o_pin_out ^ i_pin_out) & ~o_pin_override) == 3'h0)
    else $error("pin changed without override");
  AST_RESET_CMD: assert property (i_cmd_valid && i_cmd == CMD_RESET && !i_enable |=>
    o_period == PER_RESET && o_count == 16'h0000 && o_flags == 8'h00)
    else $error("reset command incomplete");
  AST_SPLIT_NOBUF: assert property (i_split_enable && i_period_buf_write |=>
    !$rose(o_buf_valid[0])) else $error("buffer valid in split");
  AST_FLAG_BITS: assert property ((o_flags & ~FLAG_MASK) == 8'h00)
    else $error("unused flag set");
  AST_SPLIT_DOWN: assert property (i_split_enable && !i_cmd_valid && o_count[7:0] != 8'h00
    |=> o_count[7:0] == $past(o_count[7:0]) || o_count[7:0] == $past(o_count[7:0]) - 8'h01)
    else $error("split low byte not counting down");
  AST_VEC_HIGH_UNDERFLOW_VECTOR: assert property (i_split_enable && o_irq == 8'h02 |-> o_vector == VEC_HIGH_UNDERFLOW_VECTOR)
    else $error("wrong high underflow vector");
endmodule : tmr_split_timer_monitor

bind tmr_split_timer tmr_split_timer_monitor mon (.*);

// ### sim/tmr_far_side.sv
// Far side: event source and port pin with optional inversion.
// Assumes the timer clock; the event changes after falling edges.
`timescale 1ns/100ps
module tmr_far_side (
  input  wire logic       i_ref_clk,
  input  wire logic       i_run,
  input  wire logic       i_invert,
  input  wire logic [2:0] i_wave,
  output logic            o_event,
  output logic [2:0]      o_level
);
  logic [1:0] phase;
  initial begin
    phase   = 2'h0;
    o_event = 1'b0;
  end
  // Square event, four cycles high, four low
  always @(negedge i_ref_clk) begin
    if (i_run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        o_event <= ~o_event;
      end
    end
  end
  assign o_level = i_wave ^ {3{i_invert}};
endmodule : tmr_far_side

// ### sim/tmr_split_timer_tb.sv
// Testbench for the split-capable timer: one task per scenario.
// Assumes the far-side model supplies the event and the pin levels.
`timescale 1ns/100ps
module tmr_split_timer_tb;
  import tmr_pkg::*;
  localparam int          DIV [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  localparam logic [15:0] EVX [5] = '{16'h0008, 16'h0010, 16'h0020, 16'h0000, 16'h0040};
  logic        i_ref_clk, i_reset, i_enable, i_sleep, i_split_enable, i_lock_update;
  logic        i_count_on_event_enable, i_cmd_valid, i_period_write, i_period_buf_write;
  logic        i_byte_write, i_byte_high, ev_run, inv, o_count_up, ev;
  logic [1:0]  i_event_action_select, i_cmd;
  logic [2:0]  i_prescaler_select, i_waveform_mode_select, i_compare_output_enable;
  logic [2:0]  i_compare_write, i_pin_out, o_pin_out, o_pin_override, lvl;
  logic [15:0] i_period_data, i_compare_data, o_count, o_period, c0, m;
  logic [7:0]  i_int_enable, i_flag_clear, o_flags, o_irq, o_vector;
  logic [3:0]  o_buf_valid;
  int          n_fail, samples_checked, cycles;

  tmr_split_timer dut (.*, .i_event(ev), .i_dir_down(1'b0), .i_period_buf_data(i_period_data),
    .i_compare_buf_write(3'h0), .i_compare_buf_data(16'h0000));
  tmr_far_side far (.i_ref_clk(i_ref_clk), .i_run(ev_run), .i_invert(inv), .i_wave(o_pin_out),
    .o_event(ev), .o_level(lvl));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : tick

  task automatic cmd(input logic [1:0] c);
    {i_cmd_valid, i_cmd} = {1'b1, c};
    tick(1);
    i_cmd_valid = 1'b0;
  endtask : cmd

  task automatic wr_per(input logic [15:0] d, input logic bw, input logic hi);
    {i_period_write, i_period_data, i_byte_write, i_byte_high} = {1'b1, d, bw, hi};
    tick(1);
    {i_period_write, i_byte_write} = 2'h0;
  endtask : wr_per

  task automatic t_reset_cmd;
    wr_per(16'h0040, 1'b0, 1'b0);
    i_enable = 1'b1;
    cmd(CMD_RESET);
    chk(o_period, 16'h0040);
    i_enable = 1'b0;
    cmd(CMD_RESET);
    chk(o_period, PER_RESET);
    $display("reset command done");
  endtask : t_reset_cmd

  task automatic t_restart_sleep;
    i_enable = 1'b1;
    tick(10);
    cmd(CMD_RESTART);
    chk(o_count, 16'h0000);
    tick(3);
    i_sleep = 1'b1;
    tick(2);
    c0 = o_count;
    tick(20);
    chk(o_count, c0);
    i_sleep = 1'b0;
    $display("restart and sleep done");
  endtask : t_restart_sleep

  task automatic t_prescale;
    for (int s = 0; s < 8; s++) begin
      i_prescaler_select = 3'(s);
      tick(DIV[s] + 2);
      c0 = o_count;
      tick(8 * DIV[s]);
      chk(o_count - c0, 16'h0008);
    end
    i_prescaler_select = 3'h0;
    $display("prescaler done");
  endtask : t_prescale

  task automatic t_event;
    ev_run = 1'b1;
    for (int a = 0; a < 5; a++) begin
      i_count_on_event_enable = (a < 4);
      i_event_action_select = 2'(a);
      tick(16);
      c0 = o_count;
      tick(64);
      chk(o_count - c0, EVX[a]);
    end
    {ev_run, i_count_on_event_enable, i_enable} = 3'h0;
    $display("events done");
  endtask : t_event

  task automatic t_update;
    {i_lock_update, i_period_buf_write, i_period_data} = {2'h3, 16'h1234};
    tick(1);
    i_period_buf_write = 1'b0;
    chk({15'h0000, o_buf_valid[0]}, 16'h0001);
    cmd(CMD_UPDATE);
    chk(o_period, 16'h1234);
    chk({15'h0000, o_buf_valid[0]}, 16'h0000);
    i_lock_update = 1'b0;
    $display("update done");
  endtask : t_update

  task automatic t_dual;
    int h;
    h = 0;
    m = 16'h0000;
    wr_per(PER_MIN, 1'b0, 1'b0);
    {i_compare_write, i_compare_data} = {3'h1, 16'h0001};
    tick(1);
    i_compare_write = 3'h0;
    {i_waveform_mode_select, i_compare_output_enable} = {WG_DSBOTH, 3'h1};
    {i_int_enable, inv, i_enable} = {8'h10, 2'h3};
    cmd(CMD_RESTART);
    tick(12);
    c0 = o_count;
    tick(6);
    chk(o_count, c0);
    repeat (24) begin
      tick(1);
      h += lvl[0];
      if (o_count > m) m = o_count;
    end
    chk(16'(h), 16'h0010);
    chk(m, PER_MIN);
    chk({13'h0000, o_pin_override}, 16'h0001);
    chk({o_irq, o_vector}, {8'h10, VEC_COMPARE0_VECTOR});
    i_enable = 1'b0;
    cmd(CMD_RESTART);
    chk({15'h0000, o_count_up}, 16'h0001);
    i_flag_clear = 8'h10;
    tick(1);
    i_flag_clear = 8'h00;
    chk({8'h00, o_irq}, 16'h0000);
    {i_compare_output_enable, inv} = 4'h0;
    $display("dual slope done");
  endtask : t_dual

  task automatic t_split;
    cmd(CMD_RESET);
    i_split_enable = 1'b1;
    wr_per(16'h0005, 1'b1, 1'b0);
    wr_per(16'h0003, 1'b1, 1'b1);
    chk(o_period, 16'h0305);
    i_period_buf_write = 1'b1;
    tick(1);
    i_period_buf_write = 1'b0;
    chk({12'h000, o_buf_valid}, 16'h0000);
    {i_waveform_mode_select, i_int_enable, i_enable} = {WG_SINGLESLOPE, 8'h02, 1'b1};
    m = 16'h0000;
    repeat (48) begin
      tick(1);
      if (o_count[7:0] > m[7:0]) m[7:0] = o_count[7:0];
      if (o_count[15:8] > m[15:8]) m[15:8] = o_count[15:8];
    end
    chk(m, 16'h0305);
    chk({15'h0000, o_count_up}, 16'h0000);
    chk({o_irq, o_vector}, {8'h02, VEC_HIGH_UNDERFLOW_VECTOR});
    i_enable = 1'b0;
    i_flag_clear = 8'h02;
    tick(1);
    i_flag_clear = 8'h00;
    chk({15'h0000, o_flags[1]}, 16'h0000);
    i_split_enable = 1'b0;
    tick(1);
    chk(o_period, 16'h0305);
    $display("split done");
  endtask : t_split

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    {i_reset, i_enable, i_sleep, i_split_enable, i_lock_update, ev_run, inv} = 7'h40;
    {i_count_on_event_enable, i_cmd_valid, i_period_write, i_period_buf_write} = 4'h0;
    {i_byte_write, i_byte_high, i_event_action_select, i_cmd, i_compare_write} = 9'h000;
    {i_prescaler_select, i_waveform_mode_select, i_compare_output_enable} = 9'h000;
    {i_period_data, i_compare_data, i_int_enable, i_flag_clear} = 48'h0;
    i_pin_out = 3'h5;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    tick(2);
    i_reset = 1'b0;
    tick(1);
    t_reset_cmd();
    t_restart_sleep();
    t_prescale();
    t_event();
    t_update();
    t_dual();
    t_split();
    conclude();
  end
endmodule : tmr_split_timer_tb
